// *** verilog/fspc_ctrl.v ***
`timescale 1ns/1ps
`default_nettype none
`include "fspc_map.vh"
module fspc_ctrl #(
   parameter AW        = 12,
   parameter DW        = 14,
   parameter TW        = 24,
   parameter HALT_CYC  = `FSPC_HALT_CYC,
   parameter PWRT_CYC  = `FSPC_PWRT_CYC,
   parameter [AW-1:0] PROT_LIMIT_0 = 12'h000,
   parameter [AW-1:0] PROT_LIMIT_1 = 12'h400,
   parameter [AW-1:0] PROT_LIMIT_2 = 12'h800
) (
   input  wire          clk,
   input  wire          resetn,
   input  wire          addr_low_we,
   input  wire          addr_high_we,
   input  wire          data_low_we,
   input  wire          data_high_we,
   input  wire          control_we,
   input  wire          unlock_we,
   input  wire [7:0]    wdata,
   input  wire [1:0]    self_protect_range,
   input  wire          code_protect,
   input  wire          ext_prog_mode,
   input  wire          ext_we,
   input  wire [AW-1:0] ext_addr,
   input  wire [DW-1:0] ext_wdata,
   output reg  [7:0]    flash_addr_low,
   output reg  [7:0]    flash_addr_high,
   output reg  [7:0]    flash_data_low,
   output reg  [7:0]    flash_data_high,
   output wire [7:0]    flash_control,
   output wire [7:0]    flash_unlock,
   output wire          program_enable,
   output wire          calibration_space_select,
   output wire          cpu_discard,
   output wire          cpu_stall,
   output reg           arr_rd,
   output reg           arr_test_sel,
   output reg  [AW-1:0] arr_addr,
   input  wire [DW-1:0] arr_rdata,
   output reg           arr_erase,
   output reg           arr_prog,
   output reg  [DW-1:0] arr_wdata,
   output wire          test_access_en
);
   localparam S_IDLE  = 6'b000001;
   localparam S_SETUP = 6'b000010;
   localparam S_ERASE = 6'b000100;
   localparam S_PROG  = 6'b001000;
   localparam S_RESUM = 6'b010000;
   localparam S_PWRT  = 6'b100000;
   reg [5:0]    st_q;
   reg          program_enable_q, cal_q, rd_q, wr_q;
   reg [1:0]    rdpipe_q;
   reg [1:0]    unl_q;
   reg          setup_q;
   reg          erase_blk_q;
   reg [1:0]    pidx_q;
   reg          rlatch_q;
   reg [AW-1:0] base_q;
   wire [AW-1:0] cur_addr = {flash_addr_high[AW-9:0], flash_addr_low};
   wire [DW-1:0] cur_data = {flash_data_high[DW-9:0], flash_data_low};
   wire          tmr_busy, tmr_done;
   reg           tmr_start;
   reg  [TW-1:0] tmr_count;
   wire [DW-1:0] buf_rdata;
   wire          buf_we;
   reg  [1:0]    buf_raddr;
   assign flash_control = {1'b1, cal_q, 3'b000, program_enable_q, wr_q, rd_q};
   assign flash_unlock  = 8'h00;
   assign program_enable = program_enable_q;
   assign calibration_space_select = cal_q;
   assign test_access_en = ~code_protect;
   function prot_hit;
      input [1:0]    rng;
      input [AW-1:0] a;
      begin
         case (rng)
            2'b00:   prot_hit = 1'b1;
            2'b01:   prot_hit = (a < PROT_LIMIT_2);
            2'b10:   prot_hit = (a < PROT_LIMIT_1);
            default: prot_hit = 1'b0;
         endcase
         if (rng == 2'b00 && PROT_LIMIT_0 != {AW{1'b0}}) begin
            prot_hit = (a >= PROT_LIMIT_0);
         end
      end
   endfunction
   wire set_wr = control_we & wdata[`FSPC_CTL_WR_BIT] & ~wr_q;
   wire set_rd = control_we & wdata[`FSPC_CTL_RD_BIT] & ~rd_q;
   wire unlocked = (unl_q == 2'b10);
   wire wr_ok = set_wr & unlocked & program_enable_q & ~cal_q & st_q[0]
                & ~prot_hit(self_protect_range, cur_addr);
   wire is_last = (cur_addr[1:0] == 2'b11);
   assign buf_we = wr_ok;
   assign cpu_discard = rdpipe_q[1];
   assign cpu_stall = ~st_q[0] & ~st_q[5];
   fspc_buf #(
      .DW    (DW),
      .AW    (2)
   ) u_buf (
      .clk   (clk),
      .we    (buf_we),
      .waddr (cur_addr[1:0]),
      .wdata (cur_data),
      .raddr (buf_raddr),
      .rdata (buf_rdata)
   );
   fspc_timer #(
      .W     (TW)
   ) u_tmr (
      .clk    (clk),
      .resetn (resetn),
      .start  (tmr_start),
      .count  (tmr_count),
      .busy   (tmr_busy),
      .done   (tmr_done)
   );
   always @* begin
      buf_raddr = pidx_q;
      tmr_start = 1'b0;
      tmr_count = HALT_CYC[TW-1:0];
      // Registered buffer read: fetch one slot ahead while programming
      if (st_q[3]) begin
         buf_raddr = pidx_q + 2'b01;
      end
      if (st_q[5] && !rlatch_q) begin
         tmr_start = 1'b1;
         tmr_count = PWRT_CYC[TW-1:0];
      end
      if (st_q[0] && wr_ok && is_last) begin
         tmr_start = 1'b1;
      end
   end
   always @(posedge clk) begin
      if (!resetn) begin
         st_q            <= S_PWRT;
         program_enable_q          <= 1'b0;
         cal_q           <= 1'b0;
         rd_q            <= 1'b0;
         wr_q            <= 1'b0;
         rdpipe_q        <= 2'b00;
         unl_q           <= 2'b00;
         setup_q         <= 1'b0;
         erase_blk_q     <= 1'b0;
         pidx_q          <= 2'b00;
         rlatch_q        <= 1'b0;
         base_q          <= `FSPC_ADDR_RST;
         flash_addr_low  <= 8'h00;
         flash_addr_high <= 8'h00;
         flash_data_low  <= 8'h00;
         flash_data_high <= 8'h00;
         arr_rd          <= 1'b0;
         arr_test_sel    <= 1'b0;
         arr_addr        <= `FSPC_ADDR_RST;
         arr_erase       <= 1'b0;
         arr_prog        <= 1'b0;
         arr_wdata       <= `FSPC_DATA_RST;
      end else begin
         arr_rd    <= 1'b0;
         arr_erase <= 1'b0;
         arr_prog  <= 1'b0;
         rlatch_q  <= 1'b0;
         if (addr_low_we) begin
            flash_addr_low <= wdata;
         end
         if (addr_high_we) begin
            flash_addr_high <= {{(16-AW){1'b0}}, wdata[AW-9:0]};
         end
         if (data_low_we) begin
            flash_data_low <= wdata;
         end
         if (data_high_we) begin
            flash_data_high <= {{(16-DW){1'b0}}, wdata[DW-9:0]};
         end
         if (control_we) begin
            program_enable_q <= wdata[`FSPC_CTL_PROGRAM_ENABLE_BIT];
            cal_q  <= wdata[`FSPC_CTL_CALIBRATION_SPACE_SELECT_BIT];
         end
         if (unlock_we) begin
            if (wdata == `FSPC_KEY_FIRST) begin
               unl_q <= 2'b01;
            end else if (wdata == `FSPC_KEY_SECOND && unl_q == 2'b01) begin
               unl_q <= 2'b10;
            end else begin
               unl_q <= 2'b00;
            end
         end else if (control_we || addr_low_we || addr_high_we || data_low_we || data_high_we) begin
            unl_q <= 2'b00;
         end
         rdpipe_q <= {rdpipe_q[0], set_rd};
         if (set_rd) begin
            rd_q <= 1'b1;
         end
         if (rdpipe_q[0]) begin
            arr_rd       <= 1'b1;
            arr_addr     <= cur_addr;
            arr_test_sel <= cal_q & ~code_protect;
         end
         if (rdpipe_q[1]) begin
            rd_q            <= 1'b0;
            flash_data_low  <= arr_rdata[7:0];
            flash_data_high <= {{(16-DW){1'b0}}, arr_rdata[DW-1:8]};
         end
         if (ext_prog_mode && ext_we && !code_protect) begin
            arr_prog  <= 1'b1;
            arr_addr  <= ext_addr;
            arr_wdata <= ext_wdata;
         end
         case (st_q)
            S_PWRT: begin
               rlatch_q <= 1'b1;
               if (rlatch_q && !tmr_busy) begin
                  st_q <= S_IDLE;
               end
            end
            S_IDLE: begin
               if (wr_ok && is_last) begin
                  wr_q        <= 1'b1;
                  st_q        <= S_SETUP;
                  setup_q     <= 1'b0;
                  erase_blk_q <= (cur_addr[3:2] == 2'b00);
                  base_q      <= {cur_addr[AW-1:2], 2'b00};
                  pidx_q      <= 2'b00;
               end
               if (wr_ok) begin
                  unl_q <= 2'b00;
               end
            end
            S_SETUP: begin
               setup_q <= 1'b1;
               if (setup_q) begin
                  st_q <= S_ERASE;
                  if (erase_blk_q) begin
                     arr_erase <= 1'b1;
                     arr_addr  <= {base_q[AW-1:4], 4'h0};
                  end
               end
            end
            S_ERASE: begin
               st_q <= S_PROG;
            end
            S_PROG: begin
               arr_prog  <= 1'b1;
               arr_addr  <= {base_q[AW-1:2], pidx_q};
               arr_wdata <= buf_rdata;
               pidx_q    <= pidx_q + 2'b01;
               if (pidx_q == 2'b11) begin
                  st_q <= S_RESUM;
               end
            end
            S_RESUM: begin
               if (tmr_done || !tmr_busy) begin
                  wr_q <= 1'b0;
                  st_q <= S_IDLE;
               end
            end
            default: begin
               st_q <= S_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// *** shared/fspc_map.vh ***
`ifndef FSPC_MAP_VH
`define FSPC_MAP_VH
// Unlock key values
`define FSPC_KEY_FIRST       8'h55
`define FSPC_KEY_SECOND      8'hAA
// Control byte field positions
`define FSPC_CTL_RD_BIT      0
`define FSPC_CTL_WR_BIT      1
`define FSPC_CTL_PROGRAM_ENABLE_BIT    2
`define FSPC_CTL_CALIBRATION_SPACE_SELECT_BIT  6
`define FSPC_CTL_ONE_BIT     7
// Reset values
`define FSPC_ADDR_RST        12'h000
`define FSPC_DATA_RST        14'h0000
// Times
`define FSPC_CLK_HZ          20000000
`define FSPC_HALT_US         4000
`define FSPC_PWRT_US         72000
`define FSPC_HALT_CYC        ((`FSPC_HALT_US * (`FSPC_CLK_HZ / 1000000)))
`define FSPC_PWRT_CYC        ((`FSPC_PWRT_US * (`FSPC_CLK_HZ / 1000000)))
`endif

// *** verilog/fspc_buf.v ***
`timescale 1ns/1ps
`default_nettype none
module fspc_buf #(
   parameter DW = 14,
   parameter AW = 2
) (
   input  wire          clk,
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [DW-1:0] wdata,
   input  wire [AW-1:0] raddr,
   output reg  [DW-1:0] rdata
);
   reg [DW-1:0] mem [0:(1<<AW)-1];
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule
`default_nettype wire

// *** verilog/fspc_timer.v ***
`timescale 1ns/1ps
`default_nettype none
module fspc_timer #(
   parameter W = 24
) (
   input  wire         clk,
   input  wire         resetn,
   input  wire         start,
   input  wire [W-1:0] count,
   output wire         busy,
   output reg          done
);
   reg [W-1:0] cnt_q;
   assign busy = (cnt_q != {W{1'b0}});
   always @(posedge clk) begin
      if (!resetn) begin
         cnt_q <= {W{1'b0}};
         done  <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            cnt_q <= count;
         end else if (busy) begin
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
            if (cnt_q == {{(W-1){1'b0}}, 1'b1}) begin
               done <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** testbench/fspc_ctrl_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module fspc_chk (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        control_we,
   input wire logic [7:0]  wdata,
   input wire logic [7:0]  flash_control,
   input wire logic [7:0]  flash_unlock,
   input wire logic [7:0]  flash_addr_low,
   input wire logic [7:0]  flash_addr_high,
   input wire logic [7:0]  flash_data_low,
   input wire logic [7:0]  flash_data_high,
   input wire logic        program_enable,
   input wire logic        calibration_space_select,
   input wire logic        cpu_discard,
   input wire logic        cpu_stall,
   input wire logic        arr_rd,
   input wire logic        arr_erase,
   input wire logic        arr_prog,
   input wire logic [11:0] arr_addr,
   input wire logic [13:0] arr_rdata,
   input wire logic        code_protect,
   input wire logic        ext_prog_mode,
   input wire logic        ext_we,
   input wire logic [11:0] ext_addr,
   input wire logic [13:0] ext_wdata,
   input wire logic [13:0] arr_wdata,
   input wire logic        test_access_en
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_rd_go; control_we && wdata[0] && !flash_control[0] && !cpu_stall |-> ##2 arr_rd; endproperty
   property p_disc; arr_rd |-> cpu_discard; endproperty
   property p_data; arr_rd |=> {flash_data_high[5:0], flash_data_low} == $past(arr_rdata); endproperty
   property p_rd_clr; $rose(flash_control[0]) |-> ##2 !flash_control[0]; endproperty
   property p_unlk; flash_unlock == 8'h00; endproperty
   property p_ers; arr_erase |-> flash_addr_low[3:0] == 4'h3; endproperty
   property p_prg_stall;
      arr_prog && !$past(ext_prog_mode && ext_we) |-> cpu_stall && !calibration_space_select;
   endproperty
   property p_prg_blk;
      arr_prog && !$past(ext_prog_mode && ext_we) |-> arr_addr[11:2] == {flash_addr_high[3:0], flash_addr_low[7:2]};
   endproperty
   property p_ext;
      ext_prog_mode && ext_we && !code_protect |=> arr_prog && arr_addr == $past(ext_addr)
         && arr_wdata == $past(ext_wdata);
   endproperty
   property p_ext_blk; ext_prog_mode && ext_we && code_protect && !cpu_stall |=> !arr_prog; endproperty
   property p_program_enable; control_we && wdata[1] && !program_enable && !cpu_stall |=> !cpu_stall [*3]; endproperty
   property p_tst; test_access_en == !code_protect; endproperty
   property p_pwr; $rose(resetn) |-> !program_enable && flash_control == 8'h80; endproperty
   a_rd_go: assert property (p_rd_go) else $error("read strobe late");
   a_disc: assert property (p_disc) else $error("no discard");
   a_data: assert property (p_data) else $error("data latch wrong");
   a_rd_clr: assert property (p_rd_clr) else $error("read bit stuck");
   a_unlk: assert property (p_unlk) else $error("unlock not zero");
   a_ers: assert property (p_ers) else $error("erase at wrong word");
   a_prg_stall: assert property (p_prg_stall) else $error("program outside stall");
   a_prg_blk: assert property (p_prg_blk) else $error("program outside block");
   a_program_enable: assert property (p_program_enable) else $error("write without enable");
   a_tst: assert property (p_tst) else $error("test access wrong");
   a_pwr: assert property (p_pwr) else $error("enable set after reset");
   a_ext: assert property (p_ext) else $error("external write lost");
   a_ext_blk: assert property (p_ext_blk) else $error("external write under code protect");
   c_ext: cover property (ext_prog_mode && ext_we && !code_protect);
   c_ers: cover property (arr_erase);
   c_prg: cover property (arr_prog);
   c_disc: cover property (cpu_discard);
endmodule
bind fspc_ctrl fspc_chk u_fspc_chk (.*);
`default_nettype wire

// *** testbench/fspc_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fspc_flash_model (
   input wire logic         clk,
   input wire logic         arr_rd,
   input wire logic         arr_test_sel,
   input wire logic         arr_erase,
   input wire logic         arr_prog,
   input wire logic [11:0]  arr_addr,
   input wire logic [13:0]  arr_wdata,
   output logic     [13:0]  arr_rdata,
   output int               n_erase,
   output int               n_prog
);
   logic [13:0] mem [0:4095];
   logic [13:0] q;
   int          hold;
   initial begin
      for (int i = 0; i < 4096; i++) mem[i] = 14'(i * 5 + 7);
      n_erase = 0;
      n_prog = 0;
      hold = 0;
      q = 14'h0000;
   end
   // Word shows while read strobe is high, held two cycles, then scrambled
   always @* arr_rdata = arr_rd ? (arr_test_sel ? ~mem[arr_addr] : mem[arr_addr]) : (hold > 0 ? q : ~q);
   always @(posedge clk) begin
      if (arr_rd) begin
         q <= arr_test_sel ? ~mem[arr_addr] : mem[arr_addr];
         hold <= 2;
      end else if (hold > 0) hold <= hold - 1;
      if (arr_erase) begin
         for (int j = 0; j < 16; j++) mem[{arr_addr[11:4], j[3:0]}] <= 14'h3fff;
         n_erase <= n_erase + 1;
      end
      if (arr_prog) begin
         mem[arr_addr] <= arr_wdata;
         n_prog <= n_prog + 1;
      end
   end
endmodule
`default_nettype wire

// *** testbench/fspc_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module fspc_ctrl_tb_top;
   logic clk = 0, resetn = 0, cp = 0;
   logic [5:0] we = 0;
   logic [7:0] wd = 0;
   logic [1:0] spr = 2'b11;
   logic [31:0] lf = 32'h0c63;
   logic [13:0] em [0:4095];
   logic [7:0] r;
   logic xm = 0, xw = 0;
   logic [11:0] xa = 0;
   logic [13:0] xd = 0;
   wire [7:0] fal, fah, fdl, fdh, fc, fu;
   wire pe, cs, disc, stall, ard, ats, aer, apr, tae;
   wire [11:0] aa;
   wire [13:0] ardd, awd;
   int err_count = 0, compares = 0, cyc = 0, ne, np;
   always #25 clk = ~clk;
   fspc_ctrl #(.HALT_CYC(20), .PWRT_CYC(400)) u_fspc_ctrl (.clk(clk), .resetn(resetn), .addr_low_we(we[0]),
      .addr_high_we(we[1]), .data_low_we(we[2]), .data_high_we(we[3]), .control_we(we[4]), .unlock_we(we[5]),
      .wdata(wd), .self_protect_range(spr), .code_protect(cp), .ext_prog_mode(xm), .ext_we(xw),
      .ext_addr(xa), .ext_wdata(xd), .flash_addr_low(fal), .flash_addr_high(fah),
      .flash_data_low(fdl), .flash_data_high(fdh), .flash_control(fc), .flash_unlock(fu), .program_enable(pe),
      .calibration_space_select(cs), .cpu_discard(disc), .cpu_stall(stall), .arr_rd(ard), .arr_test_sel(ats),
      .arr_addr(aa), .arr_rdata(ardd), .arr_erase(aer), .arr_prog(apr), .arr_wdata(awd), .test_access_en(tae));
   fspc_flash_model u_fspc_flash_model (.clk(clk), .arr_rd(ard), .arr_test_sel(ats), .arr_erase(aer),
      .arr_prog(apr), .arr_addr(aa), .arr_wdata(awd), .arr_rdata(ardd), .n_erase(ne), .n_prog(np));
   function logic [31:0] nx(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task complete_run;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task chk(string n, logic [13:0] e, logic [13:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(int s, logic [7:0] v);
      @(posedge clk);
      #5 we = 6'(1 << s);
      wd = v;
      @(posedge clk);
      #5 we = 0;
   endtask
   task rd(logic [11:0] a, logic [7:0] c = 8'h05);
      int k;
      wr(0, a[7:0]);
      wr(1, {4'h0, a[11:8]});
      wr(4, c);
      k = 0;
      while (disc !== 1'b1 && k < 10) begin
         @(posedge clk);
         #1 k++;
      end
      chk("discard", 1, disc);
      @(posedge clk);
      #1 chk("read word", (c[6] && !cp) ? ~em[a] : em[a], {fdh[5:0], fdl});
   endtask
   // External programming write of one word
   task ext(logic [11:0] a, logic [13:0] v);
      int p0;
      p0 = np;
      @(posedge clk);
      #5 xm = 1;
      xw = 1;
      xa = a;
      xd = v;
      @(posedge clk);
      #5 xw = 0;
      xm = 0;
      repeat (2) @(posedge clk);
      #1 chk("ext programs", 14'(!cp), 14'(np - p0));
      if (!cp) em[a] = v;
   endtask
   // Four triggers of one block; cw is the trigger control byte, ul sends the unlock keys
   task blk(logic [11:0] b, bit ok, logic [7:0] cw, bit ul, bit kp);
      int k, e0, p0;
      logic [13:0] v;
      e0 = ne;
      p0 = np;
      if (ok && b[3:2] == 2'b00) for (int j = 0; j < 16; j++) em[{b[11:4], j[3:0]}] = 14'h3fff;
      for (int i = 0; i < 4; i++) begin
         if (kp && i < 2) begin
            rd(b + 12'(i));
            v = {fdh[5:0], fdl};
         end else begin
            v = lf[13:0];
            lf = nx(lf);
         end
         wr(4, cw & 8'hfd);
         wr(0, 8'(b + i));
         wr(1, {4'h0, b[11:8]});
         wr(2, v[7:0]);
         wr(3, {2'b00, v[13:8]});
         if (ul) wr(5, 8'h55);
         if (ul) wr(5, 8'haa);
         wr(4, cw);
         if (ok) em[b + 12'(i)] = v;
         repeat (3) @(posedge clk);
         #1 chk("stall", 14'(i == 3 && ok), stall);
         k = 0;
         while (stall === 1'b1 && k < 300) begin
            @(posedge clk);
            #1 k++;
         end
         chk("stall end", 0, stall);
      end
      chk("erases", 14'(ok && b[3:2] == 2'b00), 14'(ne - e0));
      chk("programs", ok ? 14'h0004 : 14'h0000, 14'(np - p0));
      for (int i = 0; i < 6; i++) rd(b + 12'(i));
      $display("block test at %h done", b);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         complete_run;
      end
   end
   initial begin
      for (int i = 0; i < 4096; i++) em[i] = 14'(i * 5 + 7);
      repeat (5) @(posedge clk);
      #5 resetn = 1;
      repeat (2) @(posedge clk);
      #1 chk("control", 8'h80, fc);
      chk("unlock", 0, fu);
      blk({lf[11:4], 4'h0}, 0, 8'h06, 1, 0);
      repeat (300) @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         rd(lf[11:0]);
         lf = nx(lf);
      end
      $display("read test done");
      r = lf[11:4];
      blk({r, 4'h0}, 1, 8'h06, 1, 0);
      for (int q = 1; q < 4; q++) blk({r, 2'(q), 2'b00}, 1, 8'h06, 1, q == 1);
      blk({r, 4'h8}, 0, 8'h02, 1, 0);
      blk({r, 4'h0}, 0, 8'h06, 0, 0);
      blk({r, 4'hc}, 0, 8'h46, 1, 0);
      spr = 2'b00;
      blk({r, 4'h0}, 0, 8'h06, 1, 0);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         #5 cp = i[0];
         ext(lf[11:0], lf[31:18]);
         #1 chk("test access", 14'(!cp), tae);
         rd(lf[11:0]);
         rd(lf[11:0], 8'h45);
         lf = nx(lf);
      end
      $display("external and test area test done");
      spr = 2'b11;
      complete_run;
   end
endmodule
`default_nettype wire
